/* fup_pkg.sv */
/*
  Shared constants and types for the shutdown and page-size configuration link.
  Assumes both ends run from a 20 MHz system clock and the link is SPI mode 0.
*/
package fup_pkg;

  // System clock period
  localparam int FUP_CLK_NS = 50;

  // Opcodes and configuration sequence bytes
  localparam logic [7:0] FUP_OP_SHUTDOWN = 8'h79;
  localparam logic [7:0] FUP_CFG_B0 = 8'h3D;
  localparam logic [7:0] FUP_CFG_B1 = 8'h2A;
  localparam logic [7:0] FUP_CFG_B2 = 8'h80;
  localparam logic [7:0] FUP_CFG_B3_512 = 8'hA6;
  localparam logic [7:0] FUP_CFG_B3_528 = 8'hA7;

  // Byte index of the last sequence byte
  localparam logic [2:0] FUP_CFG_LAST = 3'h3;

  // Page sizes; standard size carries 16 extra bytes
  localparam logic [9:0] FUP_PAGE_BIN = 10'h200;
  localparam logic [9:0] FUP_PAGE_EXTRA = 10'h010;
  localparam logic [9:0] FUP_PAGE_STD = FUP_PAGE_BIN + FUP_PAGE_EXTRA;

  // Factory value of the nonvolatile size bit (0 = 528 bytes)
  localparam logic FUP_NV_FACTORY_512 = 1'b0;

  // Times in ns (plain defaults)
  localparam int FUP_SHUTDOWN_ENTRY_TIME_NS = 3000;
  localparam int FUP_SHUTDOWN_EXIT_TIME_NS = 100000;
  localparam int FUP_WAKE_PULSE_MIN_TIME_NS = 20000;
  localparam int FUP_NV_CONFIG_PROGRAM_TIME_NS = 10000000;

  // Cycle counts: longest times round down, least times round up
  localparam int FUP_ENTRY_CYC = (FUP_SHUTDOWN_ENTRY_TIME_NS / FUP_CLK_NS < 1) ? 1 :
    FUP_SHUTDOWN_ENTRY_TIME_NS / FUP_CLK_NS;
  localparam int FUP_EXIT_CYC = (FUP_SHUTDOWN_EXIT_TIME_NS / FUP_CLK_NS < 1) ? 1 :
    FUP_SHUTDOWN_EXIT_TIME_NS / FUP_CLK_NS;
  localparam int FUP_WAKE_CYC = (FUP_WAKE_PULSE_MIN_TIME_NS + FUP_CLK_NS - 1) / FUP_CLK_NS;
  localparam int FUP_PROG_CYC = (FUP_NV_CONFIG_PROGRAM_TIME_NS / FUP_CLK_NS < 1) ? 1 :
    FUP_NV_CONFIG_PROGRAM_TIME_NS / FUP_CLK_NS;

  // Host margins: cover both synchronisers and the device reaction
  localparam int FUP_HOST_GAP_CYC = 4;
  localparam int FUP_HOST_POLL_GUARD_CYC = 8;

  // Counter widths
  localparam int FUP_DEV_CNT_W = 18;
  localparam int FUP_HOST_CNT_W = 12;

  // Decoded command of a finished frame
  typedef enum logic [1:0] {
    FUP_CMD_NONE = 2'h0,
    FUP_CMD_SHUT = 2'h1,
    FUP_CMD_P512 = 2'h2,
    FUP_CMD_P528 = 2'h3
  } fup_cmd_t;

endpackage

/* fup_link_if.sv */
/*
  Link between the flash-side device end and the host controller end.
  Assumes the host drives chip select, clock and data; the device drives busy.
*/
`timescale 1ns/1ps
interface fup_link_if;
  logic cs_n;     // Chip select, active low
  logic sck;      // Serial clock made by the host
  logic mosi;     // Host to device data
  logic rdy_busy; // Device busy level, 1 = busy

  modport dev (input cs_n, input sck, input mosi, output rdy_busy);
  modport host (output cs_n, output sck, output mosi, input rdy_busy);
endinterface // fup_link_if

/* fup_dev.sv */
/*
  Device end: serial decode of the shutdown opcode and the page-size
  sequences on the link clock, power-mode and nonvolatile program control
  on the system clock.
  Assumes an SPI mode 0 host, and a system clock that runs at all times.
*/
// Functional notes
// - In shutdown every command is ignored
// - Opcode then select release enters shutdown
// - Bits after shutdown opcode are disregarded
// - Partial or unaligned frame aborts shutdown entry
// - Power-up always starts in standby
// - Shutdown opcode ignored while program runs
// - Host wakes device with long select pulse
// - Dummy byte in wake pulse is ignored
// - Frames during exit time are ignored
// - Host waits for standby before commands
// - Standard size adds 16 bytes per page
// - Size setting is nonvolatile and reversible
// - Host limits size changes to 10,000; fup_host has no such limit, the bench only checks the count
// - Factory default size is 528 bytes
// - Sequence 3D 2A 80 A6 selects 512
// - Sequence 3D 2A 80 A7 selects 528
// - Release starts timed program, busy shown
// - New size applies when program completes
// - Status flag shows configured page size
// - Host polls busy until it clears
`timescale 1ns/1ps
module fup_dev #(
  parameter int P_PROG_CYC = fup_pkg::FUP_PROG_CYC // Program time in cycles
) (
  // System clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Link
  fup_link_if.dev link,
  // Other self-timed work of the chip
  input wire logic i_ext_busy,
  // Status towards the chip
  output logic o_shutdown,
  output logic o_busy,
  output logic o_page_512,
  output logic [9:0] o_page_bytes,
  output logic o_cfg_done
);
  import fup_pkg::*;

  // One-hot power and program states
  typedef enum logic [4:0] {
    ST_STANDBY = 5'h01,
    ST_ENTER = 5'h02,
    ST_SHUT = 5'h04,
    ST_EXIT = 5'h08,
    ST_PROG = 5'h10
  } fup_dev_st_t;

  // Link-domain state
  logic frame_q;        // Set by first bit, cleared by select release
  logic [2:0] bit_q;    // Bit position inside the byte
  logic [2:0] idx_q;    // Byte index, saturating
  logic [7:0] sh_q;     // Shift register
  fup_cmd_t cmd_q;      // Command decoded so far
  logic ok_q;           // Configuration prefix still matching
  logic aligned_q;      // Last bit closed a byte
  logic tog_q = 1'b0;   // Toggles once per frame with bits; no link reset, so it starts known

  // Link-domain next values
  logic first;
  logic [2:0] bit_cur;
  logic [2:0] idx_cur;
  logic [7:0] sh_nx;
  logic byte_done;
  fup_cmd_t cmd_cur;
  fup_cmd_t cmd_d;
  logic ok_cur;
  logic ok_d;

  // Frame flag; the link clock stops between frames, so the
  // frame's own select signal ends it asynchronously
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= 1'b1;
    end
  end

  // The first bit of a frame restarts the byte machinery
  assign first = ~frame_q;
  assign bit_cur = first ? 3'h0 : bit_q;
  assign idx_cur = first ? 3'h0 : idx_q;
  assign cmd_cur = first ? FUP_CMD_NONE : cmd_q;
  assign ok_cur = first ? 1'b1 : ok_q;
  assign sh_nx = {(first ? 7'h00 : sh_q[6:0]), link.mosi};
  assign byte_done = (bit_cur == 3'h7);

  // Once a command is latched later bytes do nothing
  assign cmd_d = (cmd_cur != FUP_CMD_NONE || !byte_done) ? cmd_cur :
    (idx_cur == 3'h0 && sh_nx == FUP_OP_SHUTDOWN) ? FUP_CMD_SHUT :
    (idx_cur == FUP_CFG_LAST && ok_cur && sh_nx == FUP_CFG_B3_512) ? FUP_CMD_P512 :
    (idx_cur == FUP_CFG_LAST && ok_cur && sh_nx == FUP_CFG_B3_528) ? FUP_CMD_P528 :
    FUP_CMD_NONE;

  // Prefix tracking of the configuration sequence
  assign ok_d = !byte_done ? ok_cur :
    (idx_cur == 3'h0) ? (sh_nx == FUP_CFG_B0) :
    (idx_cur == 3'h1) ? (ok_cur && sh_nx == FUP_CFG_B1) :
    (idx_cur == 3'h2) ? (ok_cur && sh_nx == FUP_CFG_B2) :
    1'b0;

  // Shift and decode on each rising link clock edge
  always_ff @(posedge link.sck) begin
    bit_q <= bit_cur + 3'h1;
    idx_q <= (byte_done && idx_cur != 3'h7) ? idx_cur + 3'h1 : idx_cur;
    sh_q <= sh_nx;
    cmd_q <= cmd_d;
    ok_q <= ok_d;
    aligned_q <= byte_done;
    tog_q <= first ? ~tog_q : tog_q;
  end

  // System-domain crossing; link values are steady once select is high
  logic cs_m1, cs_m2, cs_m3;       // Select synchroniser plus edge stage
  logic [1:0] cmd_m1, cmd_m2;      // Command synchroniser
  logic al_m1, al_m2;              // Alignment synchroniser
  logic tog_m1, tog_m2;            // Frame toggle synchroniser
  logic tog_seen_q;                // Toggle value of the last handled frame

  // Two flops per crossing; the first flop feeds only the second
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cs_m1 <= 1'b1;
      cs_m2 <= 1'b1;
      cs_m3 <= 1'b1;
      cmd_m1 <= 2'h0;
      cmd_m2 <= 2'h0;
      al_m1 <= 1'b0;
      al_m2 <= 1'b0;
      tog_m1 <= 1'b0;
      tog_m2 <= 1'b0;
    end else begin
      cs_m1 <= link.cs_n;
      cs_m2 <= cs_m1;
      cs_m3 <= cs_m2;
      cmd_m1 <= cmd_q;
      cmd_m2 <= cmd_m1;
      al_m1 <= aligned_q;
      al_m2 <= al_m1;
      tog_m1 <= tog_q;
      tog_m2 <= tog_m1;
    end
  end

  // Frame end decode
  wire cs_rise = cs_m2 & ~cs_m3;
  wire cs_low = ~cs_m2;
  wire new_frame = (tog_m2 != tog_seen_q);
  wire good_end = cs_rise & new_frame & al_m2;
  wire is_shut = (cmd_m2 == FUP_CMD_SHUT);
  wire is_cfg = (cmd_m2 == FUP_CMD_P512) || (cmd_m2 == FUP_CMD_P528);

  // Control state
  fup_dev_st_t st_q, st_d;
  logic [FUP_DEV_CNT_W-1:0] cnt_q, cnt_d;
  logic skip_q;         // A frame began during exit time
  logic target_q;       // Size being programmed, 1 = 512
  logic busy_q;
  logic done_q;
  logic page_512_q = FUP_NV_FACTORY_512;
  logic [9:0] bytes_q;

  // Acceptance of a frame in standby; self-timed work blocks both kinds
  wire skip_now = skip_q | (st_q == ST_EXIT && cs_low);
  wire take_shut = (st_q == ST_STANDBY) & good_end & is_shut & ~skip_now & ~i_ext_busy;
  wire take_cfg = (st_q == ST_STANDBY) & good_end & is_cfg & ~skip_now & ~i_ext_busy;
  wire cnt_zero = (cnt_q == '0);

  // Next-state logic
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
    unique case (st_q)
      // Only a clean, aligned frame is acted upon
      ST_STANDBY: begin
        if (take_shut) begin
          st_d = ST_ENTER;
          cnt_d = FUP_DEV_CNT_W'(FUP_ENTRY_CYC - 1);
        end else if (take_cfg) begin
          st_d = ST_PROG;
          cnt_d = FUP_DEV_CNT_W'(P_PROG_CYC - 1);
        end
      end
      // Entry time running; frames already ignored
      ST_ENTER: begin
        if (cnt_zero) begin
          st_d = ST_SHUT;
        end
      end
      // Any select pulse wakes; its bits are not decoded
      ST_SHUT: begin
        if (cs_rise) begin
          st_d = ST_EXIT;
          cnt_d = FUP_DEV_CNT_W'(FUP_EXIT_CYC - 1);
        end
      end
      // Exit time running
      ST_EXIT: begin
        if (cnt_zero) begin
          st_d = ST_STANDBY;
        end
      end
      // Nonvolatile program running
      ST_PROG: begin
        if (cnt_zero) begin
          st_d = ST_STANDBY;
        end
      end
      default: begin
        st_d = ST_STANDBY;
      end
    endcase
  end

  // State and counter; reset stands for power-up
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      st_q <= ST_STANDBY;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Frame bookkeeping: toggle seen and exit-time skip flag
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tog_seen_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      tog_seen_q <= cs_rise ? tog_m2 : tog_seen_q;
      // Held until that frame has ended, so its end is dropped
      skip_q <= cs_rise ? 1'b0 : skip_now;
    end
  end

  // Latch the requested size when the program starts
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      target_q <= 1'b0;
    end else if (take_cfg) begin
      target_q <= (cmd_m2 == FUP_CMD_P512);
    end
  end

  // Nonvolatile size cell: deliberately outside reset so it
  // survives power cycles; written only when a program completes
  always_ff @(posedge i_mclk) begin
    if (st_q == ST_PROG && cnt_zero) begin
      page_512_q <= target_q;
    end
  end

  // Registered status outputs
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      bytes_q <= FUP_PAGE_STD;
    end else begin
      busy_q <= (st_d == ST_PROG) | i_ext_busy;
      done_q <= (st_q == ST_PROG) & cnt_zero;
      bytes_q <= page_512_q ? FUP_PAGE_BIN : FUP_PAGE_STD;
    end
  end

  // Outputs
  assign o_shutdown = st_q[2];
  assign o_busy = busy_q;
  assign o_page_512 = page_512_q;
  assign o_page_bytes = bytes_q;
  assign o_cfg_done = done_q;
  assign link.rdy_busy = busy_q;

endmodule // fup_dev

/* fup_host.sv */
/*
  Host end: sends raw frames of up to 32 bits, wake pulses, and polls
  the busy line. Makes the link clock by dividing its own clock by two.
  Assumes the user waits for o_ready before each request.
*/
`timescale 1ns/1ps
module fup_host (
  // System clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Link
  fup_link_if.host link,
  // User request
  input wire logic i_req,
  input wire logic i_wake,
  input wire logic [31:0] i_data,
  input wire logic [5:0] i_nbits,
  input wire logic i_poll,
  // User answer
  output logic o_ready,
  output logic o_done
);
  import fup_pkg::*;

  // One-hot sequencer states
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_SHIFT = 5'h02,
    HS_HOLD = 5'h04,
    HS_GAP = 5'h08,
    HS_POLL = 5'h10
  } fup_host_st_t;

  fup_host_st_t st_q;
  logic cs_n_q, sck_q, mosi_q; // Link pins
  logic [31:0] sh_q;           // Bits still to send, MSB first
  logic [5:0] left_q;          // Bits remaining
  logic [FUP_HOST_CNT_W-1:0] cnt_q;
  logic poll_q;                // Poll busy after the frame
  logic done_q;
  logic bsy_m1, bsy_m2;        // Busy synchroniser

  wire cnt_zero = (cnt_q == '0);
  wire [FUP_HOST_CNT_W-1:0] cnt_dec = cnt_q - 1'b1;

  // Busy comes from the device clock domain
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      bsy_m1 <= 1'b0;
      bsy_m2 <= 1'b0;
    end else begin
      bsy_m1 <= link.rdy_busy;
      bsy_m2 <= bsy_m1;
    end
  end

  // Sequencer
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      st_q <= HS_IDLE;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      sh_q <= 32'h0000_0000;
      left_q <= 6'h00;
      cnt_q <= '0;
      poll_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        // Start a frame or a wake pulse
        HS_IDLE: begin
          if (i_req) begin
            cs_n_q <= 1'b0;
            poll_q <= i_poll;
            if (i_wake) begin
              cnt_q <= FUP_HOST_CNT_W'(FUP_WAKE_CYC - 1);
              st_q <= HS_HOLD;
            end else begin
              mosi_q <= i_data[31];
              sh_q <= {i_data[30:0], 1'b0};
              left_q <= i_nbits;
              st_q <= HS_SHIFT;
            end
          end
        end
        // Mode 0: device samples on the rise, data moves on the fall
        HS_SHIFT: begin
          if (left_q == 6'h00) begin
            cs_n_q <= 1'b1;
            mosi_q <= 1'b0;
            cnt_q <= FUP_HOST_CNT_W'(FUP_HOST_GAP_CYC - 1);
            st_q <= HS_GAP;
          end else if (!sck_q) begin
            sck_q <= 1'b1;
          end else begin
            sck_q <= 1'b0;
            mosi_q <= sh_q[31];
            sh_q <= {sh_q[30:0], 1'b0};
            left_q <= left_q - 6'h01;
          end
        end
        // Wake pulse low time, then wait the exit time
        HS_HOLD: begin
          cnt_q <= cnt_dec;
          if (cnt_zero) begin
            cs_n_q <= 1'b1;
            cnt_q <= FUP_HOST_CNT_W'(FUP_EXIT_CYC + FUP_HOST_GAP_CYC);
            st_q <= HS_GAP;
          end
        end
        // Select high gap between frames
        HS_GAP: begin
          cnt_q <= cnt_dec;
          if (cnt_zero) begin
            cnt_q <= FUP_HOST_CNT_W'(FUP_HOST_POLL_GUARD_CYC - 1);
            st_q <= poll_q ? HS_POLL : HS_IDLE;
            done_q <= ~poll_q;
          end
        end
        // Guard covers the device reaction, then wait for ready
        HS_POLL: begin
          cnt_q <= cnt_zero ? cnt_q : cnt_dec;
          if (cnt_zero && !bsy_m2) begin
            st_q <= HS_IDLE;
            done_q <= 1'b1;
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  // Outputs
  assign o_ready = (st_q == HS_IDLE);
  assign o_done = done_q;
  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.mosi = mosi_q;

endmodule // fup_host

/* fup_props.sv */
/*
  Checker for the wire between the host end and the device end.
  Assumes it is instantiated beside the link interface and sees its signals.
*/
`timescale 1ns/1ps
module fup_props (
  // System clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic rdy_busy
);
  import fup_pkg::*;
  logic [11:0] low_q; // Cycles spent with select low
  logic [11:0] low_d; // Next low count, saturating
  logic seen_q; // A clock pulse came in this frame
  logic seen_d; // Next clock flag

  // Counts clear whenever select is high, so each frame starts fresh
  assign low_d = (cs_n) ? 12'h000 : low_q + {11'h000, low_q != 12'hFFF};
  assign seen_d = !cs_n && (seen_q || sck);

  // Frame length helper
  always_ff @(posedge i_mclk) begin
    low_q <= (i_rstn) ? low_d : 12'h000;
    seen_q <= i_rstn && seen_d;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  idle_sck_a: assert property (cs_n |-> !sck)
    else $error("link clock moved outside a frame");
  sck_half_a: assert property (!cs_n && sck |=> !sck)
    else $error("link clock high for two cycles");
  mosi_hold_a: assert property ($rose(sck) |-> $stable(mosi))
    else $error("data changed at a rising link clock");
  mosi_idle_a: assert property (cs_n |-> !mosi)
    else $error("data not low between frames");
  select_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("select gap too short");
  wake_len_a: assert property ($rose(cs_n) && !seen_q |-> low_q >= 12'(FUP_WAKE_CYC - 1))
    else $error("wake pulse too short");
  busy_min_a: assert property ($rose(rdy_busy) |-> rdy_busy [*8])
    else $error("busy dropped too early");
  reset_idle_a: assert property ($rose(i_rstn) |-> cs_n && !sck)
    else $error("link not idle after reset");
  busy_wait_a: assert property ($fell(rdy_busy) |-> cs_n)
    else $error("busy cleared inside a frame");

  busy_seen_c: cover property ($rose(rdy_busy));
  wake_seen_c: cover property ($rose(cs_n) && !seen_q && low_q >= 12'(FUP_WAKE_CYC - 1));
  frame_seen_c: cover property ($rose(cs_n) && seen_q);
endmodule // fup_props

/* flash_udpd_pagesize_control_tb.sv */
/*
  Self-checking bench: host end and device end joined by the link, with an
  integer model of mode and page size compared after every frame.
  Assumes the shortened program time below and the host's own link clock.
*/
`timescale 1ns/1ps
module flash_udpd_pagesize_control_tb;
  import fup_pkg::*;
  localparam int PROG = 50; // Shortened program time keeps the run short
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ext_busy = 1'b0;
  logic i_req = 1'b0;
  logic i_wake = 1'b0;
  logic [31:0] i_data = 32'h00000000;
  logic [5:0] i_nbits = 6'h00;
  logic i_poll = 1'b0;
  logic o_ready;
  logic o_done;
  logic o_shutdown;
  logic o_busy;
  logic o_page_512;
  logic [9:0] o_page_bytes;
  logic o_cfg_done;
  int num_errors = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int busy_cnt = 0; // Busy cycles in the last frame
  int done_cnt = 0; // Program completions in the last frame
  int shut_m = 0; // Model: in shutdown
  int exit_m = 0; // Model: inside exit time
  int p512_m = 0; // Model: binary size selected
  int prog_total = 0; // Size programs completed so far
  logic [15:0] seed = 16'h00AB; // Random source state
  logic [31:0] td [12] = '{32'h3D2A80A6, 32'h3D2A80A7, 32'h3D2A80A6, 32'h3D2A80A6, 32'h3D2A80A5,
    32'h3D2A80A6, 32'h79000000, 32'h79000000, 32'h79000000, 32'h79FF0000, 32'h3D2A80A6, 32'h3D2A80A6};
  logic [5:0] tn [12] = '{32, 32, 31, 24, 32, 32, 7, 12, 8, 16, 32, 32};
  logic tx [12] = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0};

  // Free-running system clock
  always #25 i_mclk = ~i_mclk;

  fup_link_if fup_link_if_i ();
  fup_dev #(.P_PROG_CYC(PROG)) fup_dev_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .link(fup_link_if_i.dev),
    .i_ext_busy(i_ext_busy), .o_shutdown(o_shutdown), .o_busy(o_busy), .o_page_512(o_page_512),
    .o_page_bytes(o_page_bytes), .o_cfg_done(o_cfg_done));
  fup_host fup_host_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .link(fup_link_if_i.host), .i_req(i_req),
    .i_wake(i_wake), .i_data(i_data), .i_nbits(i_nbits), .i_poll(i_poll), .o_ready(o_ready), .o_done(o_done));
  fup_props fup_props_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .cs_n(fup_link_if_i.cs_n),
    .sck(fup_link_if_i.sck), .mosi(fup_link_if_i.mosi), .rdy_busy(fup_link_if_i.rdy_busy));

  // Sampled off the launching edge so register updates have landed
  always @(negedge i_mclk) begin
    busy_cnt += (o_busy === 1'b1);
    done_cnt += (o_cfg_done === 1'b1);
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected action of an aligned frame in standby: 1 shut, 2 binary, 3 standard
  function automatic int decode(input logic [31:0] d, input logic [5:0] n);
    if (n >= 8 && d[31:24] == 8'h79) return 1;
    if (n == 32 && d[31:8] == 24'h3D2A80 && d[7:1] == 7'h53) return d[0] ? 3 : 2;
    return 0;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic check_state();
    check(o_shutdown, shut_m, "shutdown");
    check(o_page_512, p512_m, "page size flag");
    check(o_page_bytes, p512_m ? 512 : 512 + 16, "page bytes");
  endtask

  // One host request; the wait for its completion is bounded
  task automatic xfer(input logic [31:0] d, input logic [5:0] n, input logic p, input logic w);
    int k;
    check(o_ready, 1'b1, "host ready");
    @(posedge i_mclk);
    i_req <= 1'b1;
    i_data <= d;
    i_nbits <= n;
    i_poll <= p;
    i_wake <= w;
    @(posedge i_mclk);
    i_req <= 1'b0;
    for (k = 0; k < 6000; k++) begin
      @(negedge i_mclk);
      if (o_done === 1'b1) break;
    end
    if (k == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // Frame through the model and the design, then compare
  task automatic frame(input logic [31:0] d, input logic [5:0] n, input logic ext);
    int act;
    act = (shut_m || exit_m || ext || n % 8 != 0) ? 0 : decode(d, n);
    busy_cnt = 0;
    done_cnt = 0;
    i_ext_busy <= ext;
    xfer(d, n, !ext, 1'b0);
    @(posedge i_mclk);
    i_ext_busy <= 1'b0;
    repeat (80) @(posedge i_mclk);
    if (shut_m) begin
      shut_m = 0;
      exit_m = 1;
    end else if (act == 1) shut_m = 1;
    else if (act > 1) p512_m = (act == 2);
    check(done_cnt, act > 1, "program done");
    prog_total += done_cnt;
    if (!ext) check(busy_cnt >= PROG - 1 && busy_cnt <= PROG + 2, act > 1, "busy time");
    check_state();
  endtask

  // Lets the exit time run out
  task automatic settle();
    repeat (2100) @(posedge i_mclk);
    exit_m = 0;
  endtask

  initial begin
    int i;
    logic [15:0] r;
    logic [31:0] d;
    repeat (20) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_mclk);
    check_state();
    for (i = 0; i < 12; i++) frame(td[i], tn[i], tx[i]);
    settle();
    frame(32'h79000000, 8, 0);
    frame(32'h79000000, 8, 0);
    settle();
    frame(32'h79000000, 8, 0);
    xfer(32'h00000000, 0, 1'b0, 1'b1);
    shut_m = 0;
    check_state();
    frame(32'h3D2A80A6, 32, 0);
    for (i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      d = {r, seed};
      if (r[1:0] == 2'h0) d[31:24] = 8'h79;
      else if (r[1]) d[31:8] = 24'h3D2A80;
      if (r[1:0] == 2'h2) d[7:0] = r[2] ? 8'hA6 : 8'hA7;
      frame(d, r[3] ? 6'd32 : 6'(1 + seed % 32), r[4]);
      if (exit_m) settle();
    end
    frame(32'h79000000, 8, 0);
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_mclk);
    shut_m = 0;
    check_state();
    check(prog_total <= 10000, 1'b1, "size change budget");
    tally_and_finish();
  end
endmodule // flash_udpd_pagesize_control_tb
